/* File: mmfi_defs.svh */
`ifndef MMFI_DEFS_SVH
`define MMFI_DEFS_SVH
// Notes on behaviour
// R01: management init state ends at most 2000 ms after power-on or reset release; after module reset the code takes up to one clock longer.
// R02: host holds module reset low at least 10 us to force a reset.
// R03: interrupt output goes low within 200 ms of an interrupting condition.
// R04: reading flags clears them; interrupt releases within 500 us after that read.
// R05: receive loss sets its flag and pulls interrupt low within 100 ms.
// R06: any flag condition sets its flag and pulls interrupt low within 200 ms.
// R07: setting a mask bit stops its flag driving the interrupt within 100 ms.
// R08: clearing a mask bit lets its flag drive the interrupt again within 100 ms.
// R09: fully functional within 2 s of power-on when low power not requested.
// R10: management bus answers within 2 s of power-on.
// R11: within 2 s of power-on clear data-not-ready and pull interrupt low.
// R12: fully functional within 2 s after module reset rising edge; the code takes up to one clock longer, leaving the held state first.
// R13: dual low-power / transmit-disable pin changes role within 100 ms.
// R14: low-power pin released high drops consumption to class 1 within 100 ms.
// R15: low-power pin pulled low restores full function within 300 ms.
// R16: dual interrupt / receive-loss output changes role within 100 ms.
// R17: transmitter fault sets its flag and pulls interrupt low within 200 ms.
// R18: power override or power set written 1 drops to class 1 within 100 ms.
// R19: power override and power set cleared restore full function within 300 ms.
// R20: interrupt stays low while any unmasked flag is set.

////////////////////////////////////////////////////////////////////////////////
// timing
`define MMFI_CLK_HZ 50000000
`define MMFI_INIT_MS 2000
`define MMFI_INIT_CYC ((`MMFI_INIT_MS * (`MMFI_CLK_HZ / 1000)) - 1)

////////////////////////////////////////////////////////////////////////////////
// register indices
`define MMFI_ADDR_STATUS 8'h02
`define MMFI_ADDR_FLAGS 8'h03
`define MMFI_ADDR_MASK 8'h04
`define MMFI_ADDR_CONTROL 8'h05
`define MMFI_ADDR_LIVE 8'h06

// status bits
`define MMFI_ST_NOT_READY 0
`define MMFI_ST_LOW_POWER 1
`define MMFI_ST_INT_ACTIVE 2
`define MMFI_ST_IN_INIT 3

// flag and mask bits
`define MMFI_FL_RX_LOSS 0
`define MMFI_FL_TX_FAULT 1
`define MMFI_FL_AUX 2
`define MMFI_FL_INIT_DONE 3
`define MMFI_FL_W 4

// control bits
`define MMFI_CT_PWR_OVERRIDE 0
`define MMFI_CT_PWR_SET 1
`define MMFI_CT_PIN_TRANSMIT_DISABLE_PIN 2
`define MMFI_CT_OUT_RXLOS 3
`define MMFI_CT_W 4

// reset values
`define MMFI_RST_MASK 4'h0
`define MMFI_RST_CONTROL 4'h0
`define MMFI_CNT_W 32
`endif

/* File: mmfi_pkg.sv */
`include "mmfi_defs.svh"
package mmfi_pkg;
  typedef enum logic [1:0] {
    MMFI_HELD,
    MMFI_INIT,
    MMFI_READY
  } mmfi_state_e;

  typedef struct packed {
    mmfi_state_e st;
    logic [`MMFI_CNT_W-1:0] cnt;
    logic [`MMFI_FL_W-1:0] flags;
    logic [`MMFI_FL_W-1:0] mask;
    logic [`MMFI_CT_W-1:0] ctrl;
    logic not_ready;
    logic [7:0] rdata;
    logic int_n;
    logic low_power;
    logic full_func;
    logic tx_disable;
    logic mgmt_ready;
  } mmfi_regs_s;
endpackage

/* File: mmfi_top.sv */
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "mmfi_defs.svh"
module mmfi_top #(
  parameter int INIT_CYCLES = `MMFI_INIT_CYC
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic MODULE_RESET_N,
  input wire logic LOW_POWER_REQUEST,
  input wire logic RX_LOSS,
  input wire logic TX_FAULT,
  input wire logic AUX_FAULT,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic MODULE_INTERRUPT_N,
  output logic LOW_POWER_ACTIVE,
  output logic FULLY_FUNCTIONAL,
  output logic TRANSMIT_DISABLE,
  output logic MGMT_READY
);

  //////////////////////////////////////////////////////////////////////////////
  mmfi_pkg::mmfi_regs_s r;
  mmfi_pkg::mmfi_regs_s next_r;
  logic [`MMFI_FL_W-1:0] events;
  logic [`MMFI_FL_W-1:0] next_pending;
  logic low_power_now;
  logic init_end;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == idx);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.rdata = 8'h00;
    init_end = 1'b0;
    // conditions are level: a flag re-sets while its cause persists
    events = {1'b0, AUX_FAULT, TX_FAULT, RX_LOSS}; // R05 R06 R17
    case (r.st)
      mmfi_pkg::MMFI_HELD: begin
        next_r.cnt = '0;
        if (MODULE_RESET_N) begin
          next_r.st = mmfi_pkg::MMFI_INIT; // R12
        end
      end
      mmfi_pkg::MMFI_INIT: begin
        // fixed length init uses the whole 2 s budget, with no margin to spare
        if (r.cnt >= INIT_CYCLES[`MMFI_CNT_W-1:0]) begin
          next_r.st = mmfi_pkg::MMFI_READY; // R01
          init_end = 1'b1;
        end else begin
          next_r.cnt = r.cnt + `MMFI_CNT_W'(1);
        end
      end
      mmfi_pkg::MMFI_READY: begin
        next_r.cnt = '0;
      end
      default: begin
        next_r.st = mmfi_pkg::MMFI_HELD;
      end
    endcase
    events[`MMFI_FL_INIT_DONE] = init_end; // R11
    if (init_end) begin
      next_r.not_ready = 1'b0; // R11
    end

    if (WR) begin
      if (hit(ADDR, `MMFI_ADDR_MASK)) begin
        next_r.mask = WDATA[`MMFI_FL_W-1:0]; // R07 R08
      end
      if (hit(ADDR, `MMFI_ADDR_CONTROL)) begin
        next_r.ctrl = WDATA[`MMFI_CT_W-1:0];
      end
    end

    // set wins over the clear of a read in the same cycle
    next_r.flags = r.flags | events; // R06
    if (RD) begin
      if (hit(ADDR, `MMFI_ADDR_STATUS)) begin
        next_r.rdata = {4'h0, (r.st == mmfi_pkg::MMFI_INIT), ~r.int_n,
                        r.low_power, r.not_ready};
      end else if (hit(ADDR, `MMFI_ADDR_FLAGS)) begin
        next_r.rdata = {4'h0, r.flags};
        next_r.flags = (r.flags & ~r.flags) | events; // R04
      end else if (hit(ADDR, `MMFI_ADDR_MASK)) begin
        next_r.rdata = {4'h0, r.mask};
      end else if (hit(ADDR, `MMFI_ADDR_CONTROL)) begin
        next_r.rdata = {4'h0, r.ctrl};
      end else if (hit(ADDR, `MMFI_ADDR_LIVE)) begin
        next_r.rdata = {4'h0, 1'b0, AUX_FAULT, TX_FAULT, RX_LOSS};
      end else begin
        next_r.rdata = 8'h00;
      end
    end

    // module reset pin holds state, flags, mask and control at reset and restarts init on release
    if (!MODULE_RESET_N) begin
      next_r.st = mmfi_pkg::MMFI_HELD; // R02
      next_r.cnt = '0;
      next_r.flags = '0;
      next_r.mask = `MMFI_RST_MASK;
      next_r.ctrl = `MMFI_RST_CONTROL;
      next_r.not_ready = 1'b1;
    end

    next_pending = next_r.flags & ~next_r.mask;
    // pin and output roles follow the control bits on the next edge
    if (next_r.ctrl[`MMFI_CT_OUT_RXLOS]) begin
      next_r.int_n = ~RX_LOSS; // R16
    end else begin
      next_r.int_n = ~(|next_pending); // R03 R04 R07 R08 R20
    end

    low_power_now = next_r.ctrl[`MMFI_CT_PWR_OVERRIDE] | next_r.ctrl[`MMFI_CT_PWR_SET]; // R18 R19
    if (!next_r.ctrl[`MMFI_CT_PIN_TRANSMIT_DISABLE_PIN]) begin
      low_power_now = low_power_now | LOW_POWER_REQUEST; // R13 R14 R15
      next_r.tx_disable = 1'b0;
    end else begin
      next_r.tx_disable = LOW_POWER_REQUEST; // R13
    end
    next_r.low_power = low_power_now;
    next_r.full_func = (next_r.st == mmfi_pkg::MMFI_READY) & ~low_power_now; // R09 R12 R15 R19
    // management side answers whenever the module is not held in reset
    next_r.mgmt_ready = MODULE_RESET_N; // R10
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      r.st <= mmfi_pkg::MMFI_INIT; // R01
      r.cnt <= '0;
      r.flags <= '0;
      r.mask <= `MMFI_RST_MASK;
      r.ctrl <= `MMFI_RST_CONTROL;
      r.not_ready <= 1'b1;
      r.rdata <= 8'h00;
      r.int_n <= 1'b1;
      r.low_power <= 1'b0;
      r.full_func <= 1'b0;
      r.tx_disable <= 1'b0;
      r.mgmt_ready <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign RDATA = r.rdata;
  assign MODULE_INTERRUPT_N = r.int_n;
  assign LOW_POWER_ACTIVE = r.low_power;
  assign FULLY_FUNCTIONAL = r.full_func;
  assign TRANSMIT_DISABLE = r.tx_disable;
  assign MGMT_READY = r.mgmt_ready;

endmodule // mmfi_top

/* File: mmfi_monitor.sv */
`timescale 1ns/1ps
module mmfi_monitor (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic MODULE_RESET_N,
  input wire logic LOW_POWER_REQUEST,
  input wire logic RX_LOSS,
  input wire logic TX_FAULT,
  input wire logic AUX_FAULT,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic MODULE_INTERRUPT_N,
  input wire logic LOW_POWER_ACTIVE
);
  logic [3:0] msk;
  logic [3:0] ctl;
  logic q;
  // shadow copies, the registers themselves are not visible here
  always_ff @(posedge CLK) begin
    if (!NRST || !MODULE_RESET_N) begin
      msk <= 4'h0;
      ctl <= 4'h0;
    end else if (WR && ADDR == 8'h04) begin
      msk <= WDATA[3:0];
    end else if (WR && ADDR == 8'h05) begin
      ctl <= WDATA[3:0];
    end
  end
  assign q = MODULE_RESET_N && !WR && !ctl[3];
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_rx; q && RX_LOSS && !msk[0] |=> !MODULE_INTERRUPT_N; endproperty
  property p_tx; q && TX_FAULT && !msk[1] |=> !MODULE_INTERRUPT_N; endproperty
  property p_aux; q && AUX_FAULT && !msk[2] |=> !MODULE_INTERRUPT_N; endproperty
  property p_msk; msk == 4'hF && !ctl[3] |-> MODULE_INTERRUPT_N; endproperty
  property p_unm;
    (RX_LOSS && MODULE_RESET_N)[*2] ##0 (WR && ADDR == 8'h04 && !WDATA[0] && !ctl[3])
    |=> !MODULE_INTERRUPT_N;
  endproperty
  property p_clr;
    RD && ADDR == 8'h03 && !(RX_LOSS || TX_FAULT || AUX_FAULT) && !ctl[3] |=> MODULE_INTERRUPT_N;
  endproperty
  property p_rxo; ctl[3] |-> MODULE_INTERRUPT_N == !$past(RX_LOSS); endproperty
  property p_lp;
    $past(NRST) && $past(MODULE_RESET_N)
    |-> LOW_POWER_ACTIVE == (ctl[0] || ctl[1] || (!ctl[2] && $past(LOW_POWER_REQUEST)));
  endproperty
  a_rx: assert property (p_rx) else $error("rx loss int late");
  a_tx: assert property (p_tx) else $error("tx fault int late");
  a_aux: assert property (p_aux) else $error("aux int late");
  a_msk: assert property (p_msk) else $error("masked int low");
  a_unm: assert property (p_unm) else $error("unmask int late");
  a_clr: assert property (p_clr) else $error("int kept after read");
  a_rxo: assert property (p_rxo) else $error("rx loss role wrong");
  a_lp: assert property (p_lp) else $error("low power wrong");
  c_int: cover property ($fell(MODULE_INTERRUPT_N));
  c_rxo: cover property (ctl[3] && RX_LOSS);
  c_lp: cover property ($rose(LOW_POWER_ACTIVE));
endmodule // mmfi_monitor
bind mmfi_top mmfi_monitor u_mon (.*);

/* File: mmfi_host.sv */
`timescale 1ns/1ps
module mmfi_host (
  input wire logic CLK,
  input wire logic [7:0] RDATA,
  output logic [7:0] ADDR,
  output logic [7:0] WDATA,
  output logic WR,
  output logic RD,
  output logic MODULE_RESET_N,
  output logic LOW_POWER_REQUEST
);
  initial {ADDR, WDATA, WR, RD, MODULE_RESET_N, LOW_POWER_REQUEST} = 20'h00002;
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge CLK);
    {ADDR, RD} <= {a, 1'b1};
    @(posedge CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  // full 10 us pulse, shorter ones need not reset
  task mreset;
    @(posedge CLK);
    MODULE_RESET_N <= 1'b0;
    repeat (500) @(posedge CLK);
    MODULE_RESET_N <= 1'b1;
  endtask
  task lp(input logic v);
    @(posedge CLK);
    LOW_POWER_REQUEST <= v;
  endtask
endmodule // mmfi_host

/* File: mmfi_top_tb.sv */
`timescale 1ns/1ps
module mmfi_top_tb;
  localparam int INIT_CYCLES = 20;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic RX_LOSS = 1'b0;
  logic TX_FAULT = 1'b0;
  logic AUX_FAULT = 1'b0;
  logic MODULE_RESET_N, LOW_POWER_REQUEST, WR, RD, LOW_POWER_ACTIVE;
  logic MODULE_INTERRUPT_N, FULLY_FUNCTIONAL, TRANSMIT_DISABLE, MGMT_READY, e;
  logic [7:0] ADDR, WDATA, RDATA, q, s;
  int err_count = 0;
  int n_compared = 0;
  always #10 CLK = ~CLK;
  mmfi_top #(.INIT_CYCLES(INIT_CYCLES)) dut (.*);
  mmfi_host h (.*);
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // override or set forces class 1, the pin only counts in its low-power role
  function automatic logic exp_lp(input logic [3:0] k);
    return k[0] | k[1] | (!k[2] & k[3]);
  endfunction
  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task tick;
    @(posedge CLK);
    #1;
  endtask
  task summarize;
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    s = 8'h49;
    repeat (5) @(posedge CLK);
    NRST <= 1'b1;
    repeat (INIT_CYCLES + 4) tick;
    chk("int", MODULE_INTERRUPT_N, 0);
    h.rd(8'h02, q);
    chk("status", q, 8'h04);
    h.rd(8'h03, q);
    chk("flags", q, 8'h08);
    h.rd(8'h03, q);
    chk("flags", q, 8'h00);
    chk("int", MODULE_INTERRUPT_N, 1);
    h.rd(8'hFF, q);
    chk("unmapped", q, 8'h00);
    for (int i = 0; i < 12; i++) begin
      s = lfsr(s);
      if (i == 0) s[2:0] = 3'b111;
      {RX_LOSS, TX_FAULT, AUX_FAULT} <= s[2:0];
      tick;
      chk("int", MODULE_INTERRUPT_N, !(|s[2:0]));
      {RX_LOSS, TX_FAULT, AUX_FAULT} <= 3'b000;
      h.rd(8'h03, q);
      chk("flags", q, {5'h00, s[0], s[1], s[2]});
      chk("int", MODULE_INTERRUPT_N, 1);
    end
    {RX_LOSS, TX_FAULT, AUX_FAULT} <= 3'b111;
    h.wr(8'h04, 8'h0F);
    tick;
    chk("int", MODULE_INTERRUPT_N, 1);
    h.rd(8'h06, q);
    chk("live", q, 8'h07);
    h.wr(8'h04, 8'h0E);
    tick;
    chk("int", MODULE_INTERRUPT_N, 0);
    h.wr(8'h05, 8'h08);
    {RX_LOSS, TX_FAULT, AUX_FAULT} <= 3'b000;
    tick;
    chk("rxlos", MODULE_INTERRUPT_N, 1);
    RX_LOSS <= 1'b1;
    tick;
    chk("rxlos", MODULE_INTERRUPT_N, 0);
    RX_LOSS <= 1'b0;
    // every power control and pin role pairing
    for (int k = 0; k < 16; k++) begin
      e = exp_lp(k[3:0]);
      h.wr(8'h05, {5'h00, k[2:0]});
      h.lp(k[3]);
      tick;
      chk("lowpwr", LOW_POWER_ACTIVE, e);
      chk("full", FULLY_FUNCTIONAL, !e);
      chk("transmit_disable_pin", TRANSMIT_DISABLE, k[2] & k[3]);
      h.rd(8'h05, q);
      chk("control", q, {5'h00, k[2:0]});
      h.rd(8'h02, q);
      chk("status_lp", q[1], e);
    end
    h.lp(1'b0);
    // look inside the held window while the pulse is still low
    fork
      h.mreset;
      begin
        repeat (3) tick;
        chk("mgmt", MGMT_READY, 0);
        chk("int", MODULE_INTERRUPT_N, 1);
      end
    join
    h.rd(8'h02, q);
    chk("status", q, 8'h09);
    repeat (INIT_CYCLES + 4) tick;
    chk("mgmt", MGMT_READY, 1);
    chk("full", FULLY_FUNCTIONAL, 1);
    h.rd(8'h04, q);
    chk("mask", q, 8'h00);
    summarize;
  end
  initial begin
    repeat (5000) @(posedge CLK);
    err_count++;
    summarize;
  end
endmodule // mmfi_top_tb
